// file: include/fsp_pkg.sv
// package: constants and types of the flash self-program sequencer
// Behaviour
// - Store instruction is ignored unless the self-program fuse reads zero.
// - Flash changes a whole page at a time; erase comes before write.
// - One buffer word loads per store, before erase or between erase and write.
// - Buffer words may be loaded in any order.
// - Code 00000011 then store within four cycles erases pointer's page.
// - CPU is halted for the whole of every erase and every write.
// - Code 00000001 then store within four cycles loads data word at word field.
// - Buffer is cleared after page write, on clear bit, and on reset.
// - An EEPROM write during buffer loading discards the loaded data.
// - Code 00000101 then store within four cycles writes buffer to pointer's page.
// - Pointer low bits select word in page, upper bits select page.
// - Load-program reads bytewise, pointer bit zero picks low or high byte.
// - EEPROM write busy blocks programming commands and fuse/lock reads.
// - Writing the clear bit while filling empties the buffer.
// - Erase and write last between 3.7 ms and 4.5 ms.
package fsp_pkg;
    // wishbone byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STAT_ADDR = 8'h04;
    // program_memory_control_register layout and codes
    localparam int         CTRL_W        = 6;
    localparam int         EN_B          = 0;
    localparam int         CLR_BUF_B     = 4;
    localparam logic [5:0] CTRL_RESET    = 6'h00;
    localparam logic [5:0] CMD_LOAD      = 6'h01;
    localparam logic [5:0] CMD_ERASE     = 6'h03;
    localparam logic [5:0] CMD_WRITE     = 6'h05;
    localparam logic [5:0] CMD_FUSE      = 6'h09;
    // status register bit positions
    localparam int         STAT_BUSY_B   = 0;
    localparam int         STAT_ARMED_B  = 1;
    localparam int         STAT_FILLED_B = 2;
    localparam int         STAT_EEBUSY_B = 3;
    localparam int         STAT_SPEN_B   = 4;
    // arming windows in cycles
    localparam logic [2:0] STORE_WIN     = 3'h4;
    localparam logic [2:0] FUSE_WIN      = 3'h3;
    // pointer fields: byte_select_bit, word_in_page_field, page_address_field
    localparam int         BYTE_SEL_B    = 0;
    localparam int         WORD_LSB      = 1;
    localparam int         WORD_W        = 5;
    localparam int         PAGE_LSB      = 6;
    localparam int         PAGE_W        = 10;
    localparam int         BUF_DEPTH     = 32;
    localparam logic [15:0] BUF_BLANK    = 16'hffff;
    // operation time
    localparam int         CLK_NS        = 50;
    localparam int         OP_MIN_NS     = 3700000;
    localparam int         OP_MAX_NS     = 4500000;
    localparam int         OP_MIN_CYC    = (OP_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int         OP_MAX_CYC    = OP_MAX_NS / CLK_NS;
    localparam int         CNT_W         = 17;

    typedef enum logic [1:0] {ST_IDLE, ST_STREAM, ST_WAIT} fsp_state_t;
endpackage : fsp_pkg

// file: include/fsp_buf_if.sv
// interface: sequencer to page buffer
`timescale 1ns/10ps
`default_nettype none
interface fsp_buf_if;
    import fsp_pkg::*;
    logic              load;
    logic [WORD_W-1:0] widx;
    logic [15:0]       wdata;
    logic              clr;
    logic [WORD_W-1:0] ridx;
    logic [15:0]       rdata;
    logic              filled;
    modport seq   (output load, widx, wdata, clr, ridx, input rdata, filled);
    modport store (input load, widx, wdata, clr, ridx, output rdata, filled);
endinterface : fsp_buf_if
`default_nettype wire

// file: rtl/fsp_page_buf.sv
// temporary page buffer, flip-flop storage
`timescale 1ns/10ps
`default_nettype none
module fsp_page_buf (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // sequencer side
    fsp_buf_if.store  bus
);
    import fsp_pkg::*;

    logic [15:0]          words      [BUF_DEPTH];
    logic [15:0]          next_words [BUF_DEPTH];
    logic [BUF_DEPTH-1:0] used;
    logic [BUF_DEPTH-1:0] next_used;

    always_comb begin
        next_words = words;
        next_used  = used;
        if (bus.clr) begin
            next_used = '0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                next_words[i] = BUF_BLANK;
            end
        end else if (bus.load) begin
            next_words[bus.widx] = bus.wdata;
            next_used[bus.widx]  = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            used <= '0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                words[i] <= BUF_BLANK;
            end
        end else begin
            used  <= next_used;
            words <= next_words;
        end
    end

    assign bus.rdata  = words[bus.ridx];
    assign bus.filled = |used;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_load_stores_word: assert property (
        bus.load && !bus.clr |=> words[$past(bus.widx)] == $past(bus.wdata) && bus.filled)
        else $error("loaded word not stored");
    a_clear_empties: assert property (
        bus.clr |=> !bus.filled && words[0] == BUF_BLANK)
        else $error("clear left buffer filled");
endmodule : fsp_page_buf
`default_nettype wire

// file: rtl/fsp_flash_seq.sv
// flash self-program sequencer with wishbone control
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module fsp_flash_seq #(
    parameter int OP_CYCLES = fsp_pkg::OP_MIN_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // cpu store/load program instructions
    input  wire logic        store_prog_i,
    input  wire logic [15:0] store_ptr_i,
    input  wire logic [15:0] store_data_i,
    input  wire logic        load_prog_i,
    input  wire logic [15:0] load_ptr_i,
    output logic      [7:0]  load_data_o,
    output logic             load_valid_o,
    output logic             cpu_halt_o,
    // fuses and eeprom
    input  wire logic        self_program_enable_fuse_i,
    input  wire logic        eeprom_write_busy_i,
    input  wire logic [31:0] fuse_lock_i,
    // flash array
    output logic [fsp_pkg::PAGE_W+fsp_pkg::WORD_W-1:0] flash_raddr_o,
    input  wire logic [15:0] flash_rdata_i,
    output logic             flash_erase_o,
    output logic             flash_we_o,
    output logic [fsp_pkg::PAGE_W+fsp_pkg::WORD_W-1:0] flash_addr_o,
    output logic      [15:0] flash_wdata_o
);
    import fsp_pkg::*;

    localparam int FA_W = PAGE_W + WORD_W;

    fsp_buf_if bufc ();

    fsp_page_buf u_buf (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .bus   (bufc.store)
    );

    // bus slave state
    logic              next_ack;
    logic [31:0]       next_rdat;
    logic              wr_ctrl;
    logic              rd_req;
    // control register state
    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] next_ctrl;
    logic [2:0]        arm_cnt;
    logic [2:0]        next_arm;
    logic              armed;
    logic              spen;
    logic              store_ok;
    logic              fuse_ok;
    logic              clear_page_buffer_bit_wr;
    // operation state
    fsp_state_t        state;
    fsp_state_t        next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic [WORD_W-1:0] idx;
    logic [WORD_W-1:0] next_idx;
    logic [PAGE_W-1:0] page;
    logic [PAGE_W-1:0] next_page;
    logic              wr_op;
    logic              next_wr_op;
    logic              next_erase;
    logic              next_we;
    logic [FA_W-1:0]   next_faddr;
    logic [15:0]       next_fdata;
    logic              write_done;
    // load-program read state
    logic              rd_pend;
    logic              rd_fuse;
    logic [1:0]        rd_sel;
    logic [FA_W-1:0]   next_raddr;
    logic              next_rd_fuse;
    logic [1:0]        next_rd_sel;
    logic [7:0]        next_ldata;

    assign spen  = ~self_program_enable_fuse_i;
    assign armed = arm_cnt != 3'h0;

    // write lands on the edge the master sees ack
    assign wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                     && wb_adr_i == CTRL_ADDR && wb_sel_i[0]
                     && !eeprom_write_busy_i && state == ST_IDLE;
    assign rd_req  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign clear_page_buffer_bit_wr = wr_ctrl && wb_dat_i[CLR_BUF_B];

    assign store_ok = store_prog_i && armed && spen && state == ST_IDLE
                      && !eeprom_write_busy_i && ctrl != CMD_FUSE;
    assign fuse_ok  = load_prog_i && armed && ctrl == CMD_FUSE
                      && !eeprom_write_busy_i;

    // ---------------- wishbone slave ----------------
    always_comb begin
        next_ack  = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_rdat = 32'h0;
        if (rd_req) begin
            case (wb_adr_i)
                CTRL_ADDR: next_rdat = {26'h0, ctrl};
                STAT_ADDR: begin
                    next_rdat[STAT_BUSY_B]   = state != ST_IDLE;
                    next_rdat[STAT_ARMED_B]  = armed;
                    next_rdat[STAT_FILLED_B] = bufc.filled;
                    next_rdat[STAT_EEBUSY_B] = eeprom_write_busy_i;
                    next_rdat[STAT_SPEN_B]   = spen;
                end
                default:   next_rdat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_rdat;
        end
    end

    // ---------------- control register and arming ----------------
    always_comb begin
        next_ctrl = ctrl;
        next_arm  = arm_cnt;
        if (wr_ctrl) begin
            // clear bit acts at once and is not held
            next_ctrl            = wb_dat_i[CTRL_W-1:0];
            next_ctrl[CLR_BUF_B] = 1'b0;
            if (!next_ctrl[EN_B]) begin
                next_arm = 3'h0;
            end else if (next_ctrl == CMD_FUSE) begin
                next_arm = FUSE_WIN;
            end else begin
                next_arm = STORE_WIN;
            end
        end else if (store_ok || fuse_ok) begin
            next_ctrl = CTRL_RESET;
            next_arm  = 3'h0;
        end else if (armed) begin
            next_arm = 3'(arm_cnt - 3'h1);
            if (arm_cnt == 3'h1) begin
                next_ctrl = CTRL_RESET;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl    <= CTRL_RESET;
            arm_cnt <= 3'h0;
        end else begin
            ctrl    <= next_ctrl;
            arm_cnt <= next_arm;
        end
    end

    // ---------------- page buffer port ----------------
    // load accepted only while idle, armed and eeprom not busy
    // data pair into word field slot
    assign bufc.load  = store_ok && ctrl == CMD_LOAD;
    assign bufc.widx  = store_ptr_i[WORD_LSB +: WORD_W];
    assign bufc.wdata = store_data_i;
    assign bufc.ridx  = idx;
    // clear on bit, after write, and on eeprom write while filled
    assign bufc.clr   = clear_page_buffer_bit_wr || write_done
                        || (eeprom_write_busy_i && bufc.filled);

    // ---------------- erase / write sequencer ----------------
    assign write_done = state == ST_WAIT && cnt == CNT_W'(1) && wr_op;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_idx   = idx;
        next_page  = page;
        next_wr_op = wr_op;
        next_erase = 1'b0;
        next_we    = 1'b0;
        next_faddr = flash_addr_o;
        next_fdata = flash_wdata_o;
        case (state)
            ST_IDLE: begin
                // erase the pointer's page, data ignored
                if (store_ok && ctrl == CMD_ERASE) begin
                    next_page  = store_ptr_i[PAGE_LSB +: PAGE_W];
                    next_faddr = {store_ptr_i[PAGE_LSB +: PAGE_W], {WORD_W{1'b0}}};
                    next_erase = 1'b1;
                    next_wr_op = 1'b0;
                    next_cnt   = CNT_W'(OP_CYCLES);
                    next_state = ST_WAIT;
                end else if (store_ok && ctrl == CMD_WRITE) begin
                    next_page  = store_ptr_i[PAGE_LSB +: PAGE_W];
                    next_idx   = '0;
                    next_wr_op = 1'b1;
                    next_state = ST_STREAM;
                end
            end
            ST_STREAM: begin
                next_we    = 1'b1;
                next_faddr = {page, idx};
                next_fdata = bufc.rdata;
                next_idx   = WORD_W'(idx + 1'b1);
                if (idx == WORD_W'(BUF_DEPTH - 1)) begin
                    next_cnt   = CNT_W'(OP_CYCLES);
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                next_cnt = CNT_W'(cnt - 1'b1);
                if (cnt == CNT_W'(1)) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state         <= ST_IDLE;
            cnt           <= '0;
            idx           <= '0;
            page          <= '0;
            wr_op         <= 1'b0;
            flash_erase_o <= 1'b0;
            flash_we_o    <= 1'b0;
            flash_addr_o  <= '0;
            flash_wdata_o <= 16'h0;
        end else begin
            state         <= next_state;
            cnt           <= next_cnt;
            idx           <= next_idx;
            page          <= next_page;
            wr_op         <= next_wr_op;
            flash_erase_o <= next_erase;
            flash_we_o    <= next_we;
            flash_addr_o  <= next_faddr;
            flash_wdata_o <= next_fdata;
        end
    end

    assign cpu_halt_o = state != ST_IDLE;

    // ---------------- load-program reads ----------------
    always_comb begin
        next_raddr   = flash_raddr_o;
        next_rd_sel  = rd_sel;
        next_rd_fuse = rd_fuse;
        next_ldata   = load_data_o;
        if (load_prog_i) begin
            next_raddr   = load_ptr_i[15:1];
            next_rd_sel  = load_ptr_i[1:0];
            next_rd_fuse = fuse_ok;
        end
        if (rd_pend) begin
            if (rd_fuse) begin
                next_ldata = fuse_lock_i[{rd_sel, 3'h0} +: 8];
            // byte select bit picks the byte
            end else if (rd_sel[BYTE_SEL_B]) begin
                next_ldata = flash_rdata_i[15:8];
            end else begin
                next_ldata = flash_rdata_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_pend       <= 1'b0;
            rd_fuse       <= 1'b0;
            rd_sel        <= 2'h0;
            flash_raddr_o <= '0;
            load_data_o   <= 8'h0;
            load_valid_o  <= 1'b0;
        end else begin
            rd_pend       <= load_prog_i;
            rd_fuse       <= next_rd_fuse;
            rd_sel        <= next_rd_sel;
            flash_raddr_o <= next_raddr;
            load_data_o   <= next_ldata;
            load_valid_o  <= rd_pend;
        end
    end

    // ---------------- checks ----------------
    logic [CNT_W:0] halt_len;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_len <= '0;
        end else if (cpu_halt_o) begin
            halt_len <= (CNT_W+1)'(halt_len + 1'b1);
        end else begin
            halt_len <= '0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_arm_erase;
        wr_ctrl && wb_dat_i[CTRL_W-1:0] == CMD_ERASE;
    endsequence
    sequence s_erase_go;
        flash_erase_o && cpu_halt_o;
    endsequence

    a_fuse_gates_store: assert property (
        store_ok |-> !self_program_enable_fuse_i)
        else $error("store accepted with fuse unprogrammed");
    a_erase_in_window: assert property (
        s_arm_erase ##[1:4] (store_prog_i && armed && ctrl == CMD_ERASE && spen
                             && !eeprom_write_busy_i) |=> s_erase_go)
        else $error("erase not started inside window");
    a_halt_full_op: assert property (
        $fell(cpu_halt_o) |-> halt_len >= (CNT_W+1)'(OP_CYCLES))
        else $error("cpu released before operation time");
    a_write_streams: assert property (
        state == ST_IDLE && store_ok && ctrl == CMD_WRITE |=> ##1 flash_we_o [*8])
        else $error("page write did not stream words");
    a_write_clears: assert property (
        write_done |=> !bufc.filled && state == ST_IDLE)
        else $error("buffer kept after page write");
    a_eeprom_discard: assert property (
        eeprom_write_busy_i && bufc.filled |=> !bufc.filled)
        else $error("buffer kept across eeprom write");
    a_window_expire: assert property (
        arm_cnt == 3'h1 && !store_prog_i && !load_prog_i && !wr_ctrl |=> ctrl == CTRL_RESET)
        else $error("command bits outlived window");
    a_ctrl_blocked: assert property (
        wb_cyc_i && wb_we_i && wb_ack_o && eeprom_write_busy_i |=> $stable(ctrl))
        else $error("control written during eeprom write");
    a_byte_select: assert property (
        load_prog_i && !fuse_ok && load_ptr_i[BYTE_SEL_B]
        |-> ##2 (load_valid_o && load_data_o == $past(flash_rdata_i[15:8])))
        else $error("high byte not returned");
endmodule : fsp_flash_seq
`default_nettype wire

// file: verif/fsp_flash_model.sv
// flash array model behind the sequencer's read, erase and write strobes
`timescale 1ns/10ps
`default_nettype none
module fsp_flash_model (
    // clock
    input  wire logic                                      clk_i,
    // sequencer side
    input  wire logic [fsp_pkg::PAGE_W+fsp_pkg::WORD_W-1:0] raddr_i,
    output logic      [15:0]                               rdata_o,
    input  wire logic                                      erase_i,
    input  wire logic                                      we_i,
    input  wire logic [fsp_pkg::PAGE_W+fsp_pkg::WORD_W-1:0] addr_i,
    input  wire logic [15:0]                               wdata_i
);
    import fsp_pkg::*;
    logic [15:0] mem [0:(1<<(PAGE_W+WORD_W))-1];

    initial begin
        foreach (mem[i]) mem[i] = BUF_BLANK;
    end
    assign rdata_o = mem[addr_i == raddr_i ? addr_i : raddr_i];
    always @(posedge clk_i) begin
        // page erase, then programming can only clear bits
        // non-blocking so a read in the same edge sees the old word
        if (erase_i === 1'b1) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                mem[{addr_i[PAGE_W+WORD_W-1:WORD_W], i[WORD_W-1:0]}] <= BUF_BLANK;
            end
        end
        if (we_i === 1'b1) begin
            mem[addr_i] <= mem[addr_i] & wdata_i;
        end
    end
endmodule : fsp_flash_model
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench of the flash self-program sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("Error %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    import fsp_pkg::*;
    localparam int OPC = 20;
    // fuse and lock image, value arbitrary
    localparam logic [31:0] FUSE_VAL = 32'h5a3c_96e1;
    logic [3:0]  wb_sel_i;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        store_prog_i, load_prog_i, load_valid_o, cpu_halt_o;
    logic        fuse_i, ee_busy_i, fl_erase, fl_we;
    logic [7:0]  wb_adr_i, load_data_o;
    logic [31:0] wb_dat_i, wb_dat_o, seed, r, e;
    logic [15:0] store_ptr_i, store_data_i, load_ptr_i, fl_rdata, fl_wdata;
    logic [14:0] fl_raddr, fl_addr;
    logic [9:0]  pg;
    logic [15:0] img [BUF_DEPTH];
    logic [31:0] exp_q [$];
    int          error_cnt, checks_done;

    fsp_flash_seq #(.OP_CYCLES(OPC)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .store_prog_i(store_prog_i), .store_ptr_i(store_ptr_i), .store_data_i(store_data_i),
        .load_prog_i(load_prog_i), .load_ptr_i(load_ptr_i), .load_data_o(load_data_o),
        .load_valid_o(load_valid_o), .cpu_halt_o(cpu_halt_o),
        .self_program_enable_fuse_i(fuse_i), .eeprom_write_busy_i(ee_busy_i),
        .fuse_lock_i(FUSE_VAL), .flash_raddr_o(fl_raddr), .flash_rdata_i(fl_rdata),
        .flash_erase_o(fl_erase), .flash_we_o(fl_we), .flash_addr_o(fl_addr),
        .flash_wdata_o(fl_wdata));
    fsp_flash_model u_flash (.clk_i(clk_i), .raddr_i(fl_raddr), .rdata_o(fl_rdata),
        .erase_i(fl_erase), .we_i(fl_we), .addr_i(fl_addr), .wdata_i(fl_wdata));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    // request held until ack is sampled, then released
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, dat};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            $display("Error %0t: bus timeout", $time);
            summarize();
        end
    endtask : wb

    task automatic rd(input logic [7:0] adr, input logic [31:0] x);
        exp_q.push_back(x);
        wb(1'b0, adr, 8'h0);
    endtask : rd

    // control written only while eeprom idle
    task automatic cmd(input logic [5:0] code, input logic [15:0] ptr, input logic [15:0] d);
        wb(1'b1, CTRL_ADDR, {2'b00, code});
        @(posedge clk_i);
        store_prog_i <= 1'b1;
        store_ptr_i  <= ptr;
        store_data_i <= d;
        @(posedge clk_i);
        store_prog_i <= 1'b0;
    endtask : cmd

    task automatic halt_len(input int x);
        int n;
        n = 0;
        for (int k = 0; k < 200; k++) begin
            @(posedge clk_i);
            if (cpu_halt_o === 1'b1) n++;
            else if (n > 0 || k > 4) break;
        end
        `CHK(n, x)
    endtask : halt_len

    task automatic prog(input logic [9:0] p);
        r = rnd();
        cmd(CMD_ERASE, {p, 6'h0}, r[15:0]);
        halt_len(OPC);
        cmd(CMD_WRITE, {p, 6'h0}, r[31:16]);
        halt_len(BUF_DEPTH + OPC);
    endtask : prog

    task automatic ld(input logic [15:0] ptr, input logic [7:0] x);
        exp_q.push_back({24'h0, x});
        @(posedge clk_i);
        load_prog_i <= 1'b1;
        load_ptr_i  <= ptr;
        @(posedge clk_i);
        load_prog_i <= 1'b0;
    endtask : ld

    task automatic check_page(input logic [9:0] p);
        for (int w = 0; w < BUF_DEPTH; w++) begin
            ld({p, w[4:0], 1'b0}, img[w][7:0]);
            ld({p, w[4:0], 1'b1}, img[w][15:8]);
        end
        repeat (4) @(posedge clk_i);
    endtask : check_page

    always @(posedge clk_i) begin
        if ((wb_ack_o === 1'b1 && wb_we_i === 1'b0) || load_valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("Error %0t: result with nothing expected", $time);
            end else begin
                e = exp_q.pop_front();
                if (load_valid_o === 1'b1) `CHK({24'h0, load_data_o}, e)
                else `CHK(wb_dat_o, e)
            end
        end
    end

    initial begin
        seed = 32'd81786;
        error_cnt = 0;
        checks_done = 0;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, store_prog_i, load_prog_i} = 6'h20;
        {fuse_i, ee_busy_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
        {store_ptr_i, store_data_i, load_ptr_i} = '0;
        foreach (img[i]) img[i] = BUF_BLANK;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CTRL_ADDR, 32'h0);
        rd(STAT_ADDR, 32'h1 << STAT_SPEN_B);
        rd(8'h08, 32'h0);
        $display("reset test done");
        fuse_i <= 1'b1;
        cmd(CMD_ERASE, 16'h0040, 16'h0);
        halt_len(0);
        fuse_i <= 1'b0;
        $display("fuse test done");
        r = rnd();
        pg = r[9:0];
        wb(1'b1, CTRL_ADDR, {2'b00, CMD_LOAD});
        repeat (5) @(posedge clk_i);
        rd(CTRL_ADDR, 32'h0);
        // late store must not reach word 0
        cmd(6'h00, {pg, 6'h0}, 16'h1234);
        $display("expiry test done");
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            img[(5 * k + 3) % 32] = r[15:0];
            cmd(CMD_LOAD, {pg, 5'((5 * k + 3) % 32), 1'b0}, r[15:0]);
        end
        prog(pg);
        check_page(pg);
        foreach (img[i]) img[i] = BUF_BLANK;
        prog(pg);
        check_page(pg);
        $display("program test done");
        cmd(CMD_LOAD, {pg, 6'h06}, 16'h0000);
        wb(1'b1, CTRL_ADDR, 8'h10);
        prog(pg);
        check_page(pg);
        $display("clear test done");
        cmd(CMD_LOAD, {pg, 6'h06}, 16'h0000);
        @(posedge clk_i);
        ee_busy_i <= 1'b1;
        wb(1'b1, CTRL_ADDR, {2'b00, CMD_LOAD});
        rd(CTRL_ADDR, 32'h0);
        rd(STAT_ADDR, (32'h1 << STAT_EEBUSY_B) | (32'h1 << STAT_SPEN_B));
        ee_busy_i <= 1'b0;
        prog(pg);
        check_page(pg);
        $display("eeprom test done");
        // loaded word must not survive a mid-run reset
        cmd(CMD_LOAD, {pg, 6'h06}, 16'h0000);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        prog(pg);
        check_page(pg);
        $display("reset clear test done");
        cmd(CMD_ERASE, {pg, 6'h00}, 16'h0000);
        halt_len(OPC);
        r = rnd();
        img[9] = r[15:0];
        cmd(CMD_LOAD, {pg, 5'h09, 1'b0}, r[15:0]);
        cmd(CMD_WRITE, {pg, 6'h00}, 16'h0000);
        halt_len(BUF_DEPTH + OPC);
        check_page(pg);
        $display("fill after erase test done");
        wb(1'b1, CTRL_ADDR, {2'b00, CMD_FUSE});
        ld({pg, 6'h01}, FUSE_VAL[15:8]);
        wb(1'b1, CTRL_ADDR, {2'b00, CMD_FUSE});
        ee_busy_i <= 1'b1;
        ld({pg, 6'h01}, img[0][15:8]);
        repeat (6) @(posedge clk_i);
        ee_busy_i <= 1'b0;
        $display("fuse read test done");
        repeat (10) @(posedge clk_i);
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("Error %0t: results missing", $time);
        end
        summarize();
    end
endmodule : testbench
`default_nettype wire
